/* bench/csc_master.sv */
/*
 * SMBus master model for the charger bench: start, stop, word transfers and
 * the alert response read. Assumes the bench resolves the open-drain SDA
 * with a pull-up; pins change only after falling clock edges.
 */
`timescale 1ns/1ns
module csc_master
	import csc_pkg::*;
(
	// Clock and resolved data line.
	input  wire logic i_clock,
	input  wire logic i_sda,
	// Driven pins; a one releases the line.
	output logic      o_scl,
	output logic      o_sda
);
	// Phase length in clocks; raising it makes a slow master.
	int          half = 5;
	logic        ack;
	logic [15:0] rd_data;
	event        got;

	// Both lines idle high so no false start is seen after reset.
	initial
	begin
		o_scl = 1'b1;
		o_sda = 1'b1;
	end

	task automatic tick(input int n);
		repeat (n) @(negedge i_clock);
	endtask

	// Also serves as repeated start, since SCL is low on entry then.
	task automatic start();
		o_sda = 1'b1;
		tick(half);
		o_scl = 1'b1;
		tick(half);
		o_sda = 1'b0;
		tick(half);
		o_scl = 1'b0;
		tick(2);
	endtask

	task automatic stop();
		o_sda = 1'b0;
		tick(half);
		o_scl = 1'b1;
		tick(half);
		o_sda = 1'b1;
		tick(half);
	endtask

	// Data moves two clocks after SCL falls, never with it, so the
	// synchronised pins never show a false start or stop.
	task automatic put(input logic [7:0] b, output logic a);
		for (int i = 7; i >= -1; i--)
		begin
			o_sda = (i < 0) ? 1'b1 : b[i];
			tick(half);
			o_scl = 1'b1;
			tick(half);
			a = !i_sda;
			o_scl = 1'b0;
			tick(2);
		end
	endtask

	task automatic get(input logic nak, output logic [7:0] b);
		for (int i = 7; i >= -1; i--)
		begin
			o_sda = (i < 0) ? nak : 1'b1;
			tick(half);
			o_scl = 1'b1;
			tick(half);
			if (i >= 0)
				b = {b[6:0], i_sda};
			o_scl = 1'b0;
			tick(2);
		end
		o_sda = 1'b1;
	endtask

	// Word transfers go low byte first.
	task automatic write_word(input logic [6:0] ad, input logic [7:0] c,
		input logic [15:0] w);
		logic a;
		start();
		put({ad, 1'b0}, ack);
		put(c, a);
		put(w[7:0], a);
		put(w[15:8], a);
		stop();
	endtask

	task automatic read_word(input logic [7:0] c);
		logic       a;
		logic [7:0] lo;
		logic [7:0] hi;
		start();
		put({DEV_ADDR, 1'b0}, a);
		put(c, a);
		start();
		put({DEV_ADDR, 1'b1}, a);
		get(1'b0, lo);
		get(1'b1, hi);
		stop();
		rd_data = {hi, lo};
		-> got;
	endtask

	task automatic alert_reply();
		logic       a;
		logic [7:0] lo;
		start();
		put({ARA_ADDR, 1'b1}, a);
		get(1'b1, lo);
		stop();
		rd_data = {8'h00, lo};
		-> got;
	endtask

endmodule // csc_master

/* bench/tb_csc_charger.sv */
/*
 * Self-checking bench for the charger block: drives SMBus traffic through
 * the master model and the sense pins, queues expected read words.
 * Assumes the design's package constants and the hand-over timing.
 */
`timescale 1ns/1ns
module tb_csc_charger
	import csc_pkg::*;
;
	logic i_clock = 0, i_rst_n, i_adapter_sense_input;
	logic i_adapter_supply_input, i_charge_allow_pin;
	logic i_pack_volt_high, i_pack_curr_high, i_sense_done;
	logic [1:0] i_current_limit_resistor;
	logic [2:0] i_volt_limit_resistor;
	logic [16:0] i_pack_ohms;
	logic o_sda_out, o_sda_oe_n, o_alert_out, o_alert_oe_n, o_charge_enable;
	logic o_small_current_pulse_mode, o_current_reduce, o_voltage_reduce;
	logic [15:0] o_current_setpoint, o_voltage_setpoint, v, e, mx;
	logic [31:0] note, seed = 32'h3ab62050;
	logic [31:0] exp_q[$];
	logic m_scl, m_sda, sda_line;
	int bad_count = 0, cmp_count = 0;
	// Open-drain data line with a pull-up.
	assign sda_line = m_sda & (o_sda_oe_n | o_sda_out);
	always #10 i_clock = ~i_clock;

	csc_charger dut (.i_clock, .i_rst_n, .i_scl(m_scl), .i_sda(sda_line),
		.o_sda_out, .o_sda_oe_n, .o_alert_out, .o_alert_oe_n,
		.i_adapter_sense_input, .i_adapter_supply_input,
		.i_charge_allow_pin, .i_pack_volt_high, .i_pack_curr_high,
		.i_current_limit_resistor, .i_volt_limit_resistor, .i_pack_ohms,
		.i_sense_done, .o_charge_enable, .o_current_setpoint,
		.o_voltage_setpoint, .o_small_current_pulse_mode,
		.o_current_reduce, .o_voltage_reduce);
	csc_master m (.i_clock, .i_sda(sda_line), .o_scl(m_scl), .o_sda(m_sda));

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic cmp(input string s, input logic [15:0] g, e);
		cmp_count++;
		if (g !== e)
		begin
			bad_count++;
			$display("mismatch at %0t: %s got %h want %h", $time, s, g, e);
		end
	endtask

	// Notes an expected word under a mask, then reads it back.
	task automatic rd(input logic [7:0] c, input logic [15:0] x, msk);
		exp_q.push_back({msk, x & msk});
		m.read_word(c);
	endtask

	task automatic wr(input logic [7:0] c, input logic [15:0] w);
		m.write_word(DEV_ADDR, c, w);
	endtask

	task automatic bit1(input string s, input logic g, input logic x);
		cmp(s, {15'h0, g}, {15'h0, x});
	endtask

	task automatic ara();
		exp_q.push_back({16'h00ff, 16'h0012});
		m.alert_reply();
		bit1("alert after reply", o_alert_oe_n, 1'b1);
	endtask

	// The ohms value is held steady well around the strobe.
	task automatic sample(input logic [16:0] ohms);
		i_pack_ohms = ohms;
		m.tick(4);
		i_sense_done = 1'b1;
		m.tick(4);
		i_sense_done = 1'b0;
		m.tick(4);
	endtask

	task automatic conclude();
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// Each finished read is matched against the oldest queued note.
	always
	begin
		@(m.got);
		note = exp_q.pop_front();
		cmp("read word", m.rd_data & note[31:16], note[15:0]);
	end

	// Budget sized from the planned bus traffic with margin.
	initial
	begin
		#1900000;
		bad_count++;
		$display("mismatch at %0t: watchdog expired", $time);
		conclude();
	end

	initial
	begin
		// Idle levels: adapter and supply good, no sample, lowest limits.
		i_rst_n = 1'b0;
		i_adapter_sense_input = 1'b1;
		i_adapter_supply_input = 1'b1;
		i_charge_allow_pin = 1'b1;
		i_pack_volt_high = 1'b0;
		i_pack_curr_high = 1'b0;
		i_sense_done = 1'b0;
		i_current_limit_resistor = 2'h0;
		i_volt_limit_resistor = 3'h0;
		i_pack_ohms = 17'd10000;
		repeat (10) @(negedge i_clock);
		i_rst_n = 1'b1;
		m.tick(5);
		bit1("power-on alert", o_alert_oe_n, 1'b0);
		ara();
		sample(17'd10000);
		rd(CMD_STATUS, 16'h8010, 16'hffff);
		sample(17'd10000);
		rd(CMD_STATUS, 16'hc010, 16'hffff);
		bit1("pack alert", o_alert_oe_n, 1'b0);
		ara();
		$display("test presence done");
		for (int i = 0; i < 8; i++)
		begin
			seed = lfsr(seed);
			i_current_limit_resistor = i[1:0];
			mx = CUR_MAX[i[1:0]];
			v = i[2] ? {3'h0, seed[12:0]} : mx + 16'(i[0]);
			wr(CMD_CURRENT, v);
			e = ((v > mx) ? mx : v) & 16'hfffc;
			cmp("current", o_current_setpoint, e);
			rd(CMD_STATUS, (v > mx) ? 16'h0040 : 16'h0, 16'h0040);
		end
		for (int i = 0; i < 10; i++)
		begin
			seed = lfsr(seed);
			i_volt_limit_resistor = 3'(i % 5);
			mx = VOLT_MAX[i % 5];
			v = (i > 4) ? {1'b0, seed[14:0]} : mx + 16'(i[0]);
			wr(CMD_VOLTAGE, v);
			e = (v <= 16'h049f) ? 16'h0 : ((v > mx) ? mx : v) & 16'hfff0;
			cmp("voltage", o_voltage_setpoint, e);
			rd(CMD_STATUS, (v > mx) ? 16'h0080 : 16'h0, 16'h0080);
		end
		wr(CMD_VOLTAGE, 16'h049f);
		cmp("low voltage", o_voltage_setpoint, 16'h0);
		wr(CMD_VOLTAGE, 16'h04a0);
		cmp("voltage floor", o_voltage_setpoint, 16'h04a0);
		$display("test limits done");
		i_current_limit_resistor = 2'h0;
		wr(CMD_CURRENT, 16'h0020);
		wr(CMD_VOLTAGE, 16'h4000);
		bit1("charging", o_charge_enable, 1'b1);
		bit1("pulse on", o_small_current_pulse_mode, 1'b1);
		wr(CMD_EXT, 16'hffff);
		bit1("pulse off", o_small_current_pulse_mode, 1'b0);
		rd(CMD_EXT, {4'h1, VERSION_ID}, 16'hffff);
		wr(CMD_EXT, 16'hefff);
		rd(CMD_EXT, {4'h0, VERSION_ID}, 16'hffff);
		$display("test extension done");
		for (int j = 0; j < 2; j++)
		begin
			i_charge_allow_pin = j[0];
			i_adapter_supply_input = !j[0];
			m.tick(8);
			rd(CMD_STATUS, 16'h2000, 16'h2000);
			bit1("short stops", o_charge_enable, 1'b0);
			cmp("kept current", o_current_setpoint, 16'h0020);
			cmp("kept voltage", o_voltage_setpoint, 16'h4000);
		end
		i_adapter_supply_input = 1'b1;
		m.tick(8);
		bit1("charging back", o_charge_enable, 1'b1);
		wr(CMD_ALARM, 16'h0fff);
		rd(CMD_STATUS, 16'h0, 16'h1000);
		for (int b = 12; b < 16; b++)
		begin
			wr(CMD_ALARM, 16'h1 << b);
			rd(CMD_STATUS, 16'h1000, 16'h1000);
			bit1("alarm stops", o_charge_enable, 1'b0);
			bit1("alarm alert", o_alert_oe_n, 1'b0);
			ara();
			wr(CMD_CURRENT, 16'h0020);
			if (b == 12)
				rd(CMD_STATUS, 16'h1000, 16'h1000);
			wr(CMD_VOLTAGE, 16'h4000);
			rd(CMD_STATUS, 16'h0, 16'h1000);
		end
		wr(CMD_ALARM, 16'h8000);
		ara();
		i_adapter_sense_input = 1'b0;
		m.tick(8);
		rd(CMD_STATUS, 16'h0, 16'h9000);
		bit1("adapter alert", o_alert_oe_n, 1'b0);
		i_adapter_sense_input = 1'b1;
		m.tick(8);
		ara();
		$display("test alarm done");
		sample(17'd120000);
		rd(CMD_STATUS, 16'h8300, 16'hcf00);
		cmp("cleared current", o_current_setpoint, 16'h0);
		cmp("cleared voltage", o_voltage_setpoint, 16'h0);
		bit1("no pack stops", o_charge_enable, 1'b0);
		wr(CMD_CURRENT, 16'h0100);
		cmp("ignored write", o_current_setpoint, 16'h0);
		ara();
		m.half = 8;
		foreach (note[i])
		begin
			if (i < 6)
			begin
				v = 16'({17'd28501, 17'd28500, 17'd3149} >> (17 * (i % 3)));
				v = (i > 2) ? ((i == 3) ? 16'd574 : 16'(16'd575 + i - 4)) : v;
				sample({1'b0, v});
				e = (i > 2) ? ((i == 3) ? 16'h0c00 : 16'h0400) : 16'h0;
				e = (i == 2) ? 16'h0200 : ((i == 0) ? 16'h0400 : e);
				rd(CMD_STATUS, e, 16'h0f00);
			end
		end
		m.half = 5;
		$display("test ranges done");
		i_pack_volt_high = 1'b1;
		m.tick(5);
		bit1("current cut", o_current_reduce, 1'b1);
		i_pack_volt_high = 1'b0;
		i_pack_curr_high = 1'b1;
		m.tick(5);
		bit1("current back", o_current_reduce, 1'b0);
		bit1("voltage cut", o_voltage_reduce, 1'b1);
		m.write_word(7'h0a, CMD_CURRENT, 16'h0);
		bit1("foreign address", m.ack, 1'b0);
		rd(8'h20, 16'h0, 16'hffff);
		$display("test misc done");
		m.tick(10);
		conclude();
	end

endmodule // tb_csc_charger

/* hdl/csc_charger.sv */
/*
 * Command and status logic of a smart battery charger, reached as an SMBus
 * slave over SCL/SDA, with the status flags, request limits and alert line.
 * Assumes analog comparators and a pack sense sampler outside this block;
 * all pin inputs are asynchronous and pass two flip-flops here.
 */
`timescale 1ns/1ns

//Contract
//- Cold flag only above 28.5 kilohm; always set with over-range.
//- Warm flag only below 3150 ohm; always set with under-range.
//- Under-range flag only below 575 ohm.
//- Alarm-block flag set when an accepted alarm word inhibits charging.
//- Alarm-block cleared by both requests rewritten, adapter loss, pack loss.
//- Alert line pulled low when alarm-block becomes set.
//- Supply-short flag on low supply or allow pin low; blocks charging.
//- Supply-short keeps stored requests and does not change modes.
//- Pack-attached cleared at once on an over-range sample.
//- Pack-attached set only after two good samples in a row.
//- Pack removal zeroes requests; no charging without a pack.
//- Alert line pulled low on adapter or pack flag change.
//- Adapter flag follows adapter sense above its threshold.
//- Current request is a 16-bit mA word at 0x14, truncated to steps.
//- Current clamped to limit setting; excess sets current over-range.
//- Current reduced while pack voltage exceeds the programmed voltage.
//- Voltage word at 0x15; values 0x0001 to 0x049F act as zero.
//- Voltage clamped to limit setting; excess sets voltage over-range.
//- Voltage reduced while pack current exceeds the programmed current.
//- Alarm word bits 15..12 inhibit charging; other bits ignored.
//- Extension bit disables pulsing of currents below 1/16 full scale.
//- Extension read returns disable bit and fixed version field.
module csc_charger
	import csc_pkg::*;
(
	// Clock and reset.
	input  wire logic        i_clock,
	input  wire logic        i_rst_n,
	// SMBus pins, open drain.
	input  wire logic        i_scl,
	input  wire logic        i_sda,
	output logic             o_sda_out,
	output logic             o_sda_oe_n,
	output logic             o_alert_out,
	output logic             o_alert_oe_n,
	// Analog comparator levels and limit settings.
	input  wire logic        i_adapter_sense_input,
	input  wire logic        i_adapter_supply_input,
	input  wire logic        i_charge_allow_pin,
	input  wire logic        i_pack_volt_high,
	input  wire logic        i_pack_curr_high,
	input  wire logic [1:0]  i_current_limit_resistor,
	input  wire logic [2:0]  i_volt_limit_resistor,
	// Pack sense sampler.
	input  wire logic [16:0] i_pack_ohms,
	input  wire logic        i_sense_done,
	// Charger control outputs.
	output logic             o_charge_enable,
	output logic [15:0]      o_current_setpoint,
	output logic [15:0]      o_voltage_setpoint,
	output logic             o_small_current_pulse_mode,
	output logic             o_current_reduce,
	output logic             o_voltage_reduce
);

	csc_state_type s;
	csc_state_type next_s;

	logic          scl_rise;
	logic          scl_fall;
	logic          bus_start;
	logic          bus_stop;
	logic          sda_in;
	logic          sample_go;
	logic          wr_go;
	logic [15:0]   wr_word;
	logic [15:0]   cur_lim;
	logic [15:0]   volt_lim;
	logic [15:0]   volt_val;
	logic [2:0]    volt_sel;
	logic [15:0]   status_word;
	logic          ara_done;

	// Bus edges and conditions come from the second and third pipe stages.
	assign sda_in    = s.sda_pipe[1];
	assign scl_rise  = s.scl_pipe[1] & ~s.scl_pipe[2];
	assign scl_fall  = ~s.scl_pipe[1] & s.scl_pipe[2];
	assign bus_start = s.scl_pipe[1] & s.sda_pipe[2] & ~s.sda_pipe[1];
	assign bus_stop  = s.scl_pipe[1] & ~s.sda_pipe[2] & s.sda_pipe[1];
	assign sample_go = s.strobe_pipe[1] & ~s.strobe_pipe[2];

	// Active limits; unused voltage settings fall back to the top one.
	assign cur_lim  = CUR_MAX[s.pins_s.ilim];
	assign volt_sel = (s.pins_s.vlim > VOLT_SEL_TOP) ? VOLT_SEL_TOP
		: s.pins_s.vlim;
	assign volt_lim = VOLT_MAX[volt_sel];

	// Status word as read over the bus.
	always_comb
	begin
		status_word             = 16'h0000;
		status_word[ST_ADAPTER] = s.adapter;
		status_word[ST_PACK]    = s.pack;
		status_word[ST_PFAIL]   = s.power_fail;
		status_word[ST_ALARM]   = s.alarm;
		status_word[ST_UNDER]   = s.range.under;
		status_word[ST_WARM]    = s.range.warm;
		status_word[ST_COLD]    = s.range.cold;
		status_word[ST_OVER]    = s.range.over;
		status_word[ST_VOLT_OR] = s.volt_or;
		status_word[ST_CUR_OR]  = s.cur_or;
		status_word[ST_LEVEL]   = 1'b1;
	end

	// Next state of the whole block.
	always_comb
	begin
		next_s   = s;
		wr_go    = 1'b0;
		wr_word  = {s.shreg, s.lo};
		ara_done = 1'b0;
		volt_val = 16'h0000;
		// Input synchronisers: the first stage feeds only the second.
		next_s.scl_pipe    = {s.scl_pipe[1:0], i_scl};
		next_s.sda_pipe    = {s.sda_pipe[1:0], i_sda};
		next_s.strobe_pipe = {s.strobe_pipe[1:0], i_sense_done};
		next_s.ohm_m       = i_pack_ohms;
		next_s.ohm_s       = s.ohm_m;
		next_s.pins_m      = '{i_adapter_sense_input, i_adapter_supply_input,
			i_charge_allow_pin, i_pack_volt_high, i_pack_curr_high,
			i_current_limit_resistor, i_volt_limit_resistor};
		next_s.pins_s      = s.pins_m;

		// SMBus slave; a start anywhere restarts address reception.
		if (bus_start)
		begin
			next_s.st    = S_ADDR;
			next_s.cnt   = 4'h0;
			next_s.drive = 1'b0;
		end
		else if (bus_stop)
		begin
			next_s.st    = S_IDLE;
			next_s.drive = 1'b0;
		end
		else
		begin
			case (s.st)
				S_ADDR, S_CMD, S_WLO, S_WHI:
				begin
					if (scl_rise)
					begin
						next_s.shreg = {s.shreg[6:0], sda_in};
						next_s.cnt   = s.cnt + 4'h1;
					end
					else if (scl_fall && s.cnt == 4'h8)
					begin
						next_s.cnt   = 4'h0;
						next_s.drive = 1'b1;
						if (s.st == S_ADDR)
						begin
							next_s.is_read = s.shreg[0];
							next_s.is_ara  = 1'b0;
							next_s.st      = S_ADDR_ACK;
							if (s.cmd == CMD_STATUS)
								next_s.txw = status_word;
							else if (s.cmd == CMD_EXT)
								next_s.txw = {3'h0, s.pulse_dis, VERSION_ID};
							else
								next_s.txw = 16'h0000;
							if (s.shreg[7:1] == DEV_ADDR)
								next_s.st = S_ADDR_ACK;
							else if (s.shreg[7:1] == ARA_ADDR && s.shreg[0]
								&& !s.alert_quiet)
							begin
								next_s.is_ara = 1'b1;
								next_s.txw    = {8'h00, ARA_REPLY};
							end
							else
							begin
								// Not ours: stay off the bus until a start.
								next_s.drive = 1'b0;
								next_s.st    = S_IDLE;
							end
						end
						else if (s.st == S_CMD)
						begin
							next_s.cmd = s.shreg;
							next_s.st  = S_CMD_ACK;
						end
						else if (s.st == S_WLO)
						begin
							next_s.lo = s.shreg;
							next_s.st = S_WLO_ACK;
						end
						else
						begin
							wr_go     = 1'b1;
							next_s.st = S_WHI_ACK;
						end
					end
				end
				S_ADDR_ACK, S_CMD_ACK, S_WLO_ACK, S_WHI_ACK:
				begin
					if (scl_fall)
					begin
						next_s.drive = 1'b0;
						if (s.st == S_ADDR_ACK && s.is_read)
						begin
							next_s.st     = S_TX;
							next_s.shreg  = s.txw[7:0];
							next_s.drive  = ~s.txw[7];
							next_s.tx_idx = 1'b0;
						end
						else if (s.st == S_ADDR_ACK)
							next_s.st = S_CMD;
						else if (s.st == S_CMD_ACK)
							next_s.st = S_WLO;
						else if (s.st == S_WLO_ACK)
							next_s.st = S_WHI;
						else
							next_s.st = S_IDLE;
					end
				end
				S_TX:
				begin
					if (scl_rise)
						next_s.cnt = s.cnt + 4'h1;
					else if (scl_fall && s.cnt == 4'h8)
					begin
						next_s.drive = 1'b0;
						next_s.st    = S_TX_ACK;
					end
					else if (scl_fall)
					begin
						next_s.shreg = {s.shreg[6:0], 1'b0};
						next_s.drive = ~s.shreg[6];
					end
				end
				S_TX_ACK:
				begin
					// Low byte first; the high byte goes out only on an ack.
					if (scl_rise)
					begin
						ara_done = s.is_ara;
						if (!sda_in && !s.tx_idx && !s.is_ara)
						begin
							next_s.tx_idx = 1'b1;
							next_s.cnt    = 4'h0;
						end
						else
							next_s.st = S_IDLE;
					end
					else if (scl_fall && s.cnt == 4'h0)
					begin
						next_s.st    = S_TX;
						next_s.shreg = s.txw[15:8];
						next_s.drive = ~s.txw[15];
					end
				end
				default:
					next_s.drive = 1'b0;
			endcase
		end

		// Register writes; requests are refused while no pack is seen.
		if (wr_go && s.cmd == CMD_CURRENT && s.pack)
		begin
			next_s.cur_or  = wr_word > cur_lim;
			next_s.cur_req = ((wr_word > cur_lim) ? cur_lim : wr_word)
				& CUR_STEP_MASK;
			next_s.got_i   = 1'b1;
		end
		if (wr_go && s.cmd == CMD_VOLTAGE && s.pack)
		begin
			volt_val       = (wr_word <= VOLT_ZERO_MAX) ? 16'h0000
				: wr_word;
			next_s.volt_or  = volt_val > volt_lim;
			next_s.volt_req = ((volt_val > volt_lim) ? volt_lim : volt_val)
				& VOLT_STEP_MASK;
			next_s.got_v    = 1'b1;
		end
		if (wr_go && s.cmd == CMD_EXT)
			next_s.pulse_dis = wr_word[PULSE_BIT];

		// A lowered current limit setting pulls the stored current request down, so
		// the current setpoint never exceeds the limit that is active next cycle.
		if (next_s.cur_req > CUR_MAX[next_s.pins_s.ilim])
			next_s.cur_req = CUR_MAX[next_s.pins_s.ilim]
				& CUR_STEP_MASK;

		// Request-rewrite clear first, so that a new alarm in the same cycle wins over it.
		if (s.alarm && next_s.got_v && next_s.got_i)
			next_s.alarm = 1'b0;
		if (wr_go && s.cmd == CMD_ALARM && |(wr_word & ALARM_MASK))
		begin
			next_s.alarm = 1'b1;
			next_s.got_v = 1'b0;
			next_s.got_i = 1'b0;
		end

		// Pack sense sample classification.
		if (sample_go)
		begin
			next_s.range.over  = s.ohm_s > OVER_OHMS;
			next_s.range.cold  = s.ohm_s > COLD_OHMS
				|| s.ohm_s > OVER_OHMS;
			next_s.range.under = s.ohm_s < UNDER_OHMS;
			next_s.range.warm  = s.ohm_s < WARM_OHMS
				|| s.ohm_s < UNDER_OHMS;
			if (s.ohm_s > OVER_OHMS)
			begin
				next_s.pack     = 1'b0;
				next_s.one_good = 1'b0;
			end
			else if (s.one_good)
				next_s.pack = 1'b1;
			else
				next_s.one_good = 1'b1;
		end

		// Adapter and supply flags; the supply flag leaves requests alone.
		next_s.adapter    = s.pins_s.adapter;
		next_s.power_fail = ~s.pins_s.supply | ~s.pins_s.allow;

		// Without a pack the requests stay zero and any alarm is dropped.
		if (!next_s.pack)
		begin
			next_s.cur_req  = 16'h0000;
			next_s.volt_req = 16'h0000;
			next_s.got_v    = 1'b0;
			next_s.got_i    = 1'b0;
			next_s.alarm    = 1'b0;
		end
		if (!next_s.adapter)
			next_s.alarm = 1'b0;

		// Alert: answered alert response clears it; an adapter, pack or alarm-block event sets it.
		if (ara_done)
			next_s.alert_quiet = 1'b1;
		if (next_s.adapter != s.adapter || next_s.pack != s.pack)
			next_s.alert_quiet = 1'b0;
		if (next_s.alarm && !s.alarm)
			next_s.alert_quiet = 1'b0;

		// Charging permission and small-current pulsing.
		next_s.chg_en = next_s.pack & next_s.adapter & ~next_s.power_fail
			& ~next_s.alarm & (next_s.cur_req != 16'h0000)
			& (next_s.volt_req != 16'h0000);
		next_s.pulse  = next_s.chg_en & ~next_s.pulse_dis
			& (next_s.cur_req < ((cur_lim + 16'h0001) >> 4));
	end

	// Reset leaves the alert pending, which reports the power-on event.
	always_ff @(posedge i_clock)
	begin
		if (!i_rst_n)
			s <= '0;
		else
			s <= next_s;
	end

	// Outputs from the state register; SDA and alert drive levels tied low.
	assign o_sda_out                  = 1'b0;
	assign o_sda_oe_n                 = ~s.drive;
	assign o_alert_out                = 1'b0;
	assign o_alert_oe_n               = s.alert_quiet;
	assign o_charge_enable            = s.chg_en;
	assign o_current_setpoint         = s.cur_req;
	assign o_voltage_setpoint         = s.volt_req;
	assign o_small_current_pulse_mode = s.pulse;
	assign o_current_reduce           = s.pins_s.vhigh;
	assign o_voltage_reduce           = s.pins_s.ihigh;

	cold_covers_over_a: assert property (@(posedge i_clock)
		disable iff (!i_rst_n) s.range.over |-> s.range.cold)
		else $error("Over-range without cold flag.");
	warm_covers_under_a: assert property (@(posedge i_clock)
		disable iff (!i_rst_n) s.range.under |-> s.range.warm)
		else $error("Under-range without warm flag.");
	under_threshold_a: assert property (@(posedge i_clock)
		disable iff (!i_rst_n) sample_go && s.ohm_s >= UNDER_OHMS
		|=> !s.range.under)
		else $error("Under-range set at or above threshold.");
	pack_drop_a: assert property (@(posedge i_clock)
		disable iff (!i_rst_n) sample_go && s.ohm_s > OVER_OHMS |=> !s.pack)
		else $error("Pack flag kept after over-range sample.");
	pack_zero_a: assert property (@(posedge i_clock)
		disable iff (!i_rst_n) !s.pack |-> s.cur_req == 16'h0000
		&& s.volt_req == 16'h0000 && !o_charge_enable)
		else $error("Requests or charging without a pack.");
	supply_block_a: assert property (@(posedge i_clock)
		disable iff (!i_rst_n) s.power_fail |-> !o_charge_enable)
		else $error("Charging while supply short.");
	alarm_alert_a: assert property (@(posedge i_clock)
		disable iff (!i_rst_n) $rose(s.alarm) |-> !o_alert_oe_n)
		else $error("Alarm set without alert.");
	change_alert_a: assert property (@(posedge i_clock)
		disable iff (!i_rst_n) $changed(s.pack) || $changed(s.adapter)
		|-> !o_alert_oe_n)
		else $error("Flag change without alert.");
	current_clamp_a: assert property (@(posedge i_clock)
		disable iff (!i_rst_n) 1'b1 |-> o_current_setpoint <= cur_lim)
		else $error("Current setpoint above limit.");

endmodule // csc_charger

/* pkg/csc_pkg.sv */
/*
 * Shared constants and types for the charger command and status block:
 * bus addresses, command codes, limits, status layout and the state record.
 * Assumes a single 50 MHz clock and a synchronous active-low reset.
 */
package csc_pkg;

	// Bus addresses (7-bit) and the byte returned on an alert response.
	localparam logic [6:0]  DEV_ADDR  = 7'h09;
	localparam logic [6:0]  ARA_ADDR  = 7'h0c;
	localparam logic [7:0]  ARA_REPLY = 8'h12;

	// Command codes.
	localparam logic [7:0]  CMD_STATUS  = 8'h13;
	localparam logic [7:0]  CMD_CURRENT = 8'h14;
	localparam logic [7:0]  CMD_VOLTAGE = 8'h15;
	localparam logic [7:0]  CMD_ALARM   = 8'h16;
	localparam logic [7:0]  CMD_EXT     = 8'h3c;

	// Pack sense thresholds in ohms: 100000, 28500, 3150 and 575.
	localparam logic [16:0] OVER_OHMS  = 17'h186a0;
	localparam logic [16:0] COLD_OHMS  = 17'h06f54;
	localparam logic [16:0] WARM_OHMS  = 17'h00c4e;
	localparam logic [16:0] UNDER_OHMS = 17'h0023f;

	// Request limits per limit-resistor setting, highest setting first.
	localparam logic [3:0][15:0] CUR_MAX =
		{16'h0fff, 16'h0bff, 16'h07ff, 16'h03ff};
	localparam logic [4:0][15:0] VOLT_MAX =
		{16'h6d5f, 16'h54cf, 16'h43ff, 16'h332f, 16'h225f};
	localparam logic [2:0]  VOLT_SEL_TOP   = 3'h4;
	localparam logic [15:0] VOLT_ZERO_MAX  = 16'h049f;
	localparam logic [15:0] CUR_STEP_MASK  = 16'hfffc;
	localparam logic [15:0] VOLT_STEP_MASK = 16'hfff0;
	localparam logic [15:0] ALARM_MASK     = 16'hf000;

	// Extension word: pulse disable bit and version field.
	localparam int          PULSE_BIT  = 12;
	localparam logic [11:0] VERSION_ID = 12'h0a5; // Arbitrary value.

	// Status word bit positions.
	localparam int ST_ADAPTER = 15;
	localparam int ST_PACK    = 14;
	localparam int ST_PFAIL   = 13;
	localparam int ST_ALARM   = 12;
	localparam int ST_UNDER   = 11;
	localparam int ST_WARM    = 10;
	localparam int ST_COLD    = 9;
	localparam int ST_OVER    = 8;
	localparam int ST_VOLT_OR = 7;
	localparam int ST_CUR_OR  = 6;
	localparam int ST_LEVEL   = 4;

	typedef enum logic [3:0] {
		S_IDLE, S_ADDR, S_ADDR_ACK, S_CMD, S_CMD_ACK, S_WLO, S_WLO_ACK,
		S_WHI, S_WHI_ACK, S_TX, S_TX_ACK
	} csc_bus_state_type;

	typedef struct packed {
		logic       adapter;
		logic       supply;
		logic       allow;
		logic       vhigh;
		logic       ihigh;
		logic [1:0] ilim;
		logic [2:0] vlim;
	} csc_pins_type;

	typedef struct packed {
		logic cold;
		logic warm;
		logic under;
		logic over;
	} csc_range_type;

	typedef struct packed {
		logic [2:0]        scl_pipe;
		logic [2:0]        sda_pipe;
		logic [2:0]        strobe_pipe;
		logic [16:0]       ohm_m;
		logic [16:0]       ohm_s;
		csc_pins_type      pins_m;
		csc_pins_type      pins_s;
		csc_bus_state_type st;
		logic [3:0]        cnt;
		logic [7:0]        shreg;
		logic [7:0]        cmd;
		logic [7:0]        lo;
		logic [15:0]       txw;
		logic              tx_idx;
		logic              is_read;
		logic              is_ara;
		logic              drive;
		logic [15:0]       cur_req;
		logic [15:0]       volt_req;
		logic              cur_or;
		logic              volt_or;
		logic              alarm;
		logic              got_v;
		logic              got_i;
		logic              pulse_dis;
		csc_range_type     range;
		logic              pack;
		logic              one_good;
		logic              adapter;
		logic              power_fail;
		logic              alert_quiet;
		logic              chg_en;
		logic              pulse;
	} csc_state_type;

endpackage
